/* File: design/scg_defines.svh */
// Offsets, field positions, reset values and clock figures of the block
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

`define SCG_ADDR_W          4
`define SCG_DATA_W          16
`define SCG_OFF_GPS         4'h_000B
`define SCG_OFF_PCE         4'h_000C
`define SCG_OFF_SAHI        4'h_000D
`define SCG_OFF_SALO        4'h_000E

`define SCG_GPS_MASK        16'h_4FFF
`define SCG_PCE_MASK        16'h_A055
`define SCG_SAHI_MASK       16'h_0003
`define SCG_SALO_MASK       16'h_FFFF

`define SCG_GPS_RST         16'h_0000
`define SCG_PCE_RST         16'h_0000
`define SCG_SAHI_RST        2'h_3
`define SCG_SALO_RST        16'h_FFFF

`define SCG_GPS_PCR         14
`define SCG_GPS_B7          11
`define SCG_GPS_B0          4
`define SCG_GPS_A5_HI       3
`define SCG_GPS_A5_LO       2
`define SCG_GPS_A4_HI       1
`define SCG_GPS_A4_LO       0

`define SCG_PCE_I2C         15
`define SCG_PCE_ADC         13
`define SCG_PCE_TMR         6
`define SCG_PCE_SCI         4
`define SCG_PCE_SPI         2
`define SCG_PCE_PWM         0

`define SCG_MCLK_DIV        2
`define SCG_MCLK_MAX_MHZ    64
`define SCG_SYS_MAX_MHZ     32
`define SCG_FAST_MAX_MHZ    96
`define SCG_CLK_MHZ         125

`endif

/* File: design/scg_pkg.sv */
// Types shared by the clock gate and pin select block
package scg_pkg;

  // Peripheral side drivers toward the pins
  typedef struct packed {
    logic       txd;
    logic       scl_o;
    logic       scl_oe;
    logic       sda_o;
    logic       sda_oe;
    logic [3:0] tmr_o;
    logic [3:0] tmr_oe;
    logic       clock_out_pin;
    logic       mosi_o;
    logic       mosi_oe;
    logic       miso_o;
    logic       miso_oe;
    logic       ss_o;
    logic       ss_oe;
    logic       sclk_o;
    logic       sclk_oe;
    logic       pwm4;
    logic       pwm5;
  } scg_periph_drv_t;

  // Pin values delivered to the peripherals
  typedef struct packed {
    logic       rxd;
    logic       scl;
    logic       sda;
    logic [3:0] tmr;
    logic [3:1] fault;
    logic       mosi;
    logic       miso;
    logic       ss;
    logic       sclk;
  } scg_periph_rcv_t;

  // Gated clock enables, one per peripheral
  typedef struct packed {
    logic i2c;
    logic adc;
    logic tmr;
    logic async_serial;
    logic spi;
    logic pwm;
  } scg_clk_en_t;

endpackage

/* File: design/scg_top.sv */
// Clock gating, PWM rate select, pin function select and short address
//
// Design decision made here: the address-and-strobe port.
`include "scg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module scg_top #(
  parameter int DIV = `SCG_MCLK_DIV
) (
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      SYS_RST,
  // Register port
  input  wire logic [`SCG_ADDR_W-1:0]    ADDR,
  input  wire logic [`SCG_DATA_W-1:0]    WDATA,
  input  wire logic                      WR,
  input  wire logic                      RD,
  output logic      [`SCG_DATA_W-1:0]    RDATA,
  // Clock controls
  input  wire logic                      PLL_SEL,
  input  wire logic                      SYS_RUN,
  output logic                           SYS_CLK_EN,
  output scg_pkg::scg_clk_en_t           PERIPH_CLK_EN,
  output logic                           PWM_FAST_SEL,
  output logic                           FAST_CLK_EN,
  // Pin enables from the GPIO ports
  input  wire logic [7:0]                PB_PERIPH_EN,
  input  wire logic [5:4]                PA_PERIPH_EN,
  // Pins
  input  wire logic [7:0]                PB_IN,
  output logic      [7:0]                PB_OUT,
  output logic      [7:0]                PB_OE,
  input  wire logic [5:4]                PA_IN,
  output logic      [5:4]                PA_OUT,
  output logic      [5:4]                PA_OE,
  // Peripheral side
  input  wire scg_pkg::scg_periph_drv_t  PERIPH_DRV,
  output scg_pkg::scg_periph_rcv_t       PERIPH_RCV,
  // Short address path
  input  wire logic [5:0]                SHORT_OFFSET,
  output logic      [23:0]               SHORT_ADDR
);
  import scg_pkg::*;

  if (DIV != 2)
  begin : g_div_check
    $error("scg_top: only a divide by two is supported");
  end

  logic [15:0] gps_q;
  logic [15:0] pce_q;
  logic [1:0]  sahi_q;
  logic [15:0] salo_q;
  logic        tick_q;
  logic        wr_gps;
  logic        wr_pce;
  logic        wr_sahi;
  logic        wr_salo;
  logic        pwm_fast;

  assign wr_gps  = WR && (ADDR == `SCG_OFF_GPS);
  assign wr_pce  = WR && (ADDR == `SCG_OFF_PCE);
  assign wr_sahi = WR && (ADDR == `SCG_OFF_SAHI);
  assign wr_salo = WR && (ADDR == `SCG_OFF_SALO);

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      gps_q <= `SCG_GPS_RST;
    else if (wr_gps)
      gps_q <= WDATA & `SCG_GPS_MASK;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      pce_q <= `SCG_PCE_RST;
    else if (wr_pce)
      pce_q <= WDATA & `SCG_PCE_MASK;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      sahi_q <= `SCG_SAHI_RST;
      salo_q <= `SCG_SALO_RST;
    end
    else
    begin
      if (wr_sahi)
        sahi_q <= WDATA[1:0];
      if (wr_salo)
        salo_q <= WDATA;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || !RD)
      RDATA <= 16'h_0000;
    else
    begin
      case (ADDR)
        `SCG_OFF_GPS:  RDATA <= gps_q;
        `SCG_OFF_PCE:  RDATA <= pce_q;
        `SCG_OFF_SAHI: RDATA <= {14'h_0000, sahi_q};
        `SCG_OFF_SALO: RDATA <= salo_q;
        default:       RDATA <= 16'h_0000;
      endcase
    end
  end

  // Master clock halved: one enable every second edge
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      tick_q <= 1'b0;
    else
      tick_q <= ~tick_q;
  end

  // Fast rate needs both the select bit and a running PLL
  assign pwm_fast = gps_q[`SCG_GPS_PCR] && PLL_SEL;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      SYS_CLK_EN    <= 1'b0;
      PERIPH_CLK_EN <= '0;
      PWM_FAST_SEL  <= 1'b0;
      FAST_CLK_EN   <= 1'b0;
    end
    else
    begin
      SYS_CLK_EN        <= tick_q && SYS_RUN;
      PERIPH_CLK_EN.i2c <= tick_q && SYS_RUN
                           && pce_q[`SCG_PCE_I2C];
      PERIPH_CLK_EN.adc <= tick_q && SYS_RUN
                           && pce_q[`SCG_PCE_ADC];
      PERIPH_CLK_EN.tmr <= tick_q && SYS_RUN
                           && pce_q[`SCG_PCE_TMR];
      PERIPH_CLK_EN.async_serial <= tick_q && SYS_RUN
                           && pce_q[`SCG_PCE_SCI];
      PERIPH_CLK_EN.spi <= tick_q && SYS_RUN
                           && pce_q[`SCG_PCE_SPI];
      // Fast PWM enable holds high; the fast clock itself comes from
      // the synthesiser, this block only picks it
      PERIPH_CLK_EN.pwm <= (pwm_fast || tick_q) && SYS_RUN
                           && pce_q[`SCG_PCE_PWM];
      PWM_FAST_SEL      <= pwm_fast;
      FAST_CLK_EN       <= PLL_SEL;
    end
  end

  // Pin output multiplexing
  logic [7:0] pb_o;
  logic [7:0] pb_e;
  logic [5:4] pa_o;
  logic [5:4] pa_e;
  logic [1:0] a5_sel;
  logic [1:0] a4_sel;

  assign a5_sel = gps_q[`SCG_GPS_A5_HI:`SCG_GPS_A5_LO];
  assign a4_sel = gps_q[`SCG_GPS_A4_HI:`SCG_GPS_A4_LO];

  always_comb
  begin
    pb_o = 8'h_00;
    pb_e = 8'h_00;
    if (gps_q[11])
    begin
      pb_o[7] = PERIPH_DRV.scl_o;
      pb_e[7] = PERIPH_DRV.scl_oe;
    end
    else
    begin
      pb_o[7] = PERIPH_DRV.txd;
      pb_e[7] = 1'b1;
    end
    if (gps_q[10])
    begin
      pb_o[6] = PERIPH_DRV.sda_o;
      pb_e[6] = PERIPH_DRV.sda_oe;
    end
    if (!gps_q[9])
    begin
      pb_o[5] = PERIPH_DRV.tmr_o[1];
      pb_e[5] = PERIPH_DRV.tmr_oe[1];
    end
    if (gps_q[8])
    begin
      pb_o[4] = PERIPH_DRV.clock_out_pin;
      pb_e[4] = 1'b1;
    end
    else
    begin
      pb_o[4] = PERIPH_DRV.tmr_o[0];
      pb_e[4] = PERIPH_DRV.tmr_oe[0];
    end
    pb_o[3] = gps_q[7] ? PERIPH_DRV.tmr_o[3]  : PERIPH_DRV.mosi_o;
    pb_e[3] = gps_q[7] ? PERIPH_DRV.tmr_oe[3] : PERIPH_DRV.mosi_oe;
    pb_o[2] = gps_q[6] ? PERIPH_DRV.tmr_o[2]  : PERIPH_DRV.miso_o;
    pb_e[2] = gps_q[6] ? PERIPH_DRV.tmr_oe[2] : PERIPH_DRV.miso_oe;
    pb_o[1] = gps_q[5] ? PERIPH_DRV.sda_o     : PERIPH_DRV.ss_o;
    pb_e[1] = gps_q[5] ? PERIPH_DRV.sda_oe    : PERIPH_DRV.ss_oe;
    pb_o[0] = gps_q[4] ? PERIPH_DRV.scl_o     : PERIPH_DRV.sclk_o;
    pb_e[0] = gps_q[4] ? PERIPH_DRV.scl_oe    : PERIPH_DRV.sclk_oe;
    // Port A: 00 and 01 both mean PWM output
    case (a5_sel)
      2'b10:   begin pa_o[5] = 1'b0; pa_e[5] = 1'b0; end
      2'b11:   begin pa_o[5] = PERIPH_DRV.tmr_o[3];
                     pa_e[5] = PERIPH_DRV.tmr_oe[3]; end
      default: begin pa_o[5] = PERIPH_DRV.pwm5; pa_e[5] = 1'b1; end
    endcase
    case (a4_sel)
      2'b10:   begin pa_o[4] = 1'b0; pa_e[4] = 1'b0; end
      2'b11:   begin pa_o[4] = PERIPH_DRV.tmr_o[2];
                     pa_e[4] = PERIPH_DRV.tmr_oe[2]; end
      default: begin pa_o[4] = PERIPH_DRV.pwm4; pa_e[4] = 1'b1; end
    endcase
  end

  // Pin input routing; a pin only counts while its enable is set
  logic [7:0] pb_v;
  logic [5:4] pa_v;
  scg_periph_rcv_t rcv_d;

  assign pb_v = PB_IN & PB_PERIPH_EN;
  assign pa_v = PA_IN & PA_PERIPH_EN;

  always_comb
  begin
    rcv_d        = '0;
    rcv_d.rxd    = pb_v[6] && !gps_q[10];
    rcv_d.scl    = (pb_v[7] && gps_q[11])
                   || (pb_v[0] && gps_q[4]);
    rcv_d.sda    = (pb_v[6] && gps_q[10])
                   || (pb_v[1] && gps_q[5]);
    rcv_d.tmr[0] = pb_v[4] && !gps_q[8];
    rcv_d.tmr[1] = pb_v[5] && !gps_q[9];
    rcv_d.tmr[2] = (pb_v[2] && gps_q[6])
                   || (pa_v[4] && a4_sel == 2'b11);
    rcv_d.tmr[3] = (pb_v[3] && gps_q[7])
                   || (pa_v[5] && a5_sel == 2'b11);
    rcv_d.fault[3] = pb_v[5] && gps_q[9];
    rcv_d.fault[2] = pa_v[5] && a5_sel == 2'b10;
    rcv_d.fault[1] = pa_v[4] && a4_sel == 2'b10;
    rcv_d.mosi   = pb_v[3] && !gps_q[7];
    rcv_d.miso   = pb_v[2] && !gps_q[6];
    rcv_d.ss     = pb_v[1] && !gps_q[5];
    rcv_d.sclk   = pb_v[0] && !gps_q[4];
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      PB_OUT     <= 8'h_00;
      PB_OE      <= 8'h_00;
      PA_OUT     <= 2'h_0;
      PA_OE      <= 2'h_0;
      PERIPH_RCV <= '0;
    end
    else
    begin
      PB_OUT     <= pb_o & PB_PERIPH_EN;
      PB_OE      <= pb_e & PB_PERIPH_EN;
      PA_OUT     <= pa_o & PA_PERIPH_EN;
      PA_OE      <= pa_e & PA_PERIPH_EN;
      PERIPH_RCV <= rcv_d;
    end
  end

  // Short address uses the base as it stands; software keeps its wait
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      SHORT_ADDR <= 24'h_FF_FFC0;
    else
      SHORT_ADDR <= {sahi_q, salo_q, SHORT_OFFSET};
  end

  // Checks
  sequence s_read(logic [3:0] a);
    RD && ADDR == a;
  endsequence

  a_gate_reserved: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_read(`SCG_OFF_PCE) |=> (RDATA & ~`SCG_PCE_MASK) == 16'h_0000)
    else $error("reserved gate bits read nonzero");

  a_gps_write_read: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr_gps ##1 s_read(`SCG_OFF_GPS)
      |=> RDATA == ($past(WDATA, 2) & `SCG_GPS_MASK))
    else $error("select register readback wrong");

  a_gate_reset: assert property (@(posedge CLK)
    $fell(SYS_RST) |-> pce_q == 16'h_0000)
    else $error("gate register not cleared by reset");

  a_base_reset: assert property (@(posedge CLK)
    $fell(SYS_RST) |-> sahi_q == 2'b11 && salo_q == 16'h_FFFF)
    else $error("short base reset value wrong");

  a_short_addr: assert property (@(posedge CLK) disable iff (SYS_RST)
    ##1 SHORT_ADDR == {$past(sahi_q), $past(salo_q),
                       $past(SHORT_OFFSET)})
    else $error("short address not formed from base and offset");

  a_sys_halved: assert property (@(posedge CLK) disable iff (SYS_RST)
    SYS_CLK_EN |=> !SYS_CLK_EN)
    else $error("system enable faster than half rate");

  a_pwm_no_pll: assert property (@(posedge CLK) disable iff (SYS_RST)
    !PLL_SEL |=> !PWM_FAST_SEL)
    else $error("fast PWM without PLL");

  a_fast_off: assert property (@(posedge CLK) disable iff (SYS_RST)
    !PLL_SEL |=> !FAST_CLK_EN)
    else $error("fast clock running without PLL");

  a_gate_off_tmr: assert property (@(posedge CLK) disable iff (SYS_RST)
    !pce_q[`SCG_PCE_TMR] |=> !PERIPH_CLK_EN.tmr)
    else $error("timer clock runs with enable clear");

  a_gate_off_i2c: assert property (@(posedge CLK) disable iff (SYS_RST)
    !pce_q[`SCG_PCE_I2C] |=> !PERIPH_CLK_EN.i2c)
    else $error("serial bus clock runs with enable clear");

  a_pwm_rate: assert property (@(posedge CLK) disable iff (SYS_RST)
    pce_q[`SCG_PCE_PWM] && SYS_RUN && !pwm_fast
      ##1 PERIPH_CLK_EN.pwm |=> !PERIPH_CLK_EN.pwm)
    else $error("PWM clock not at system rate");

  a_pin_disabled: assert property (@(posedge CLK) disable iff (SYS_RST)
    !PB_PERIPH_EN[4] |=> !PB_OE[4] && !PB_OUT[4])
    else $error("peripheral drives pin without enable");

  a_or_inputs: assert property (@(posedge CLK) disable iff (SYS_RST)
    gps_q[11] && gps_q[4] && pb_v[0] && !pb_v[7] |=> PERIPH_RCV.scl)
    else $error("shared input not ORed");

endmodule

`default_nettype wire

/* File: dv/scg_top_tb.sv */
// Self-checking testbench for the clock gate and pin select block
`include "scg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module scg_top_tb;
  import scg_pkg::*;

  logic            clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic [3:0]      addr = 4'h0;
  logic [15:0]     wdata = 16'h0000;
  logic            wr_stb = 1'b0;
  logic            rd_stb = 1'b0;
  logic [15:0]     rdata;
  logic            pll_sel = 1'b0;
  logic            sys_run = 1'b1;
  logic            sys_clk_en;
  scg_clk_en_t     pclk;
  logic            pwm_fast;
  logic            fast_en;
  logic [7:0]      pb_en = 8'h00;
  logic [1:0]      pa_en = 2'h0;
  logic [7:0]      pb_in = 8'h00;
  logic [7:0]      pb_out;
  logic [7:0]      pb_oe;
  logic [1:0]      pa_in = 2'h0;
  logic [1:0]      pa_out;
  logic [1:0]      pa_oe;
  scg_periph_drv_t drv = '0;
  scg_periph_rcv_t rcv;
  logic [5:0]      short_off = 6'h00;
  logic [23:0]     short_addr;
  int              error_cnt = 0;
  int              n_compared = 0;
  int              sys_n;
  int              pn[6];
  logic [15:0]     d;
  logic [19:0]     ep;

  // Register table: offset, reset value, writable mask
  logic [3:0]  offs[5] = '{4'hB, 4'hC, 4'hD, 4'hE, 4'h3};
  logic [15:0] rstv[5] = '{16'h0000, 16'h0000, 16'h0003, 16'hFFFF, 16'h0000};
  logic [15:0] msk[5] = '{16'h4FFF, 16'hA055, 16'h0003, 16'hFFFF, 16'h0000};
  int          gbit[6] = '{15, 13, 6, 4, 2, 0};
  // Pin cases: two-source pairs, disabled pins, every port A code
  logic [15:0] ps[4] = '{16'h0000, 16'h0FFF, 16'h0FFA, 16'h0FF5};
  logic [7:0]  pe[4] = '{8'hFF, 8'hFF, 8'hA5, 8'hFF};
  logic [7:0]  pi[4] = '{8'h5A, 8'h81, 8'hFF, 8'h01};
  logic [1:0]  ae[4] = '{2'h3, 2'h3, 2'h1, 2'h3};
  logic [1:0]  ai[4] = '{2'h3, 2'h3, 2'h2, 2'h1};
  logic [23:0] dv[4] = '{24'h5A_5AC3, 24'hA5_A53C, 24'h0F_0F0F, 24'hFF_FFFF};

  scg_top dut (
    .CLK           (clk),
    .SYS_RST       (sys_rst),
    .ADDR          (addr),
    .WDATA         (wdata),
    .WR            (wr_stb),
    .RD            (rd_stb),
    .RDATA         (rdata),
    .PLL_SEL       (pll_sel),
    .SYS_RUN       (sys_run),
    .SYS_CLK_EN    (sys_clk_en),
    .PERIPH_CLK_EN (pclk),
    .PWM_FAST_SEL  (pwm_fast),
    .FAST_CLK_EN   (fast_en),
    .PB_PERIPH_EN  (pb_en),
    .PA_PERIPH_EN  (pa_en),
    .PB_IN         (pb_in),
    .PB_OUT        (pb_out),
    .PB_OE         (pb_oe),
    .PA_IN         (pa_in),
    .PA_OUT        (pa_out),
    .PA_OE         (pa_oe),
    .PERIPH_DRV    (drv),
    .PERIPH_RCV    (rcv),
    .SHORT_OFFSET  (short_off),
    .SHORT_ADDR    (short_addr)
  );

  always #4 clk = ~clk;

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_cnt(input string n, input int e, input int g);
    n_compared++;
    if (g != e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask

  // Write then read with no gap between the strobes
  task automatic bus_wr_rd(input logic [3:0] a, input logic [15:0] v,
                           output logic [15:0] r);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 r = rdata;
  endtask

  // Enables are pulses, so count highs over eight cycles
  task automatic count8;
    sys_n = 0;
    foreach (pn[i]) pn[i] = 0;
    repeat (8)
    begin
      @(posedge clk);
      #1 sys_n += (sys_clk_en === 1'b1);
      for (int i = 0; i < 6; i++) pn[i] += (pclk[i] === 1'b1);
    end
  endtask

  function automatic logic [19:0] exp_pins(input logic [15:0] s,
      input logic [7:0] be, input logic [1:0] en, input scg_periph_drv_t q);
    logic [7:0] o;
    logic [7:0] e;
    logic [1:0] ao;
    logic [1:0] aoe;
    {o[7], e[7]} = s[11] ? {q.scl_o, q.scl_oe} : {q.txd, 1'b1};
    {o[6], e[6]} = s[10] ? {q.sda_o, q.sda_oe} : 2'b00;
    {o[5], e[5]} = s[9] ? 2'b00 : {q.tmr_o[1], q.tmr_oe[1]};
    {o[4], e[4]} = s[8] ? {q.clock_out_pin, 1'b1} : {q.tmr_o[0], q.tmr_oe[0]};
    {o[3], e[3]} = s[7] ? {q.tmr_o[3], q.tmr_oe[3]} : {q.mosi_o, q.mosi_oe};
    {o[2], e[2]} = s[6] ? {q.tmr_o[2], q.tmr_oe[2]} : {q.miso_o, q.miso_oe};
    {o[1], e[1]} = s[5] ? {q.sda_o, q.sda_oe} : {q.ss_o, q.ss_oe};
    {o[0], e[0]} = s[4] ? {q.scl_o, q.scl_oe} : {q.sclk_o, q.sclk_oe};
    {ao[1], aoe[1]} = s[3] ? (s[2] ? {q.tmr_o[3], q.tmr_oe[3]} : 2'b00)
                           : {q.pwm5, 1'b1};
    {ao[0], aoe[0]} = s[1] ? (s[0] ? {q.tmr_o[2], q.tmr_oe[2]} : 2'b00)
                           : {q.pwm4, 1'b1};
    return {aoe & en, ao & aoe & en, e & be, o & e & be};
  endfunction

  function automatic scg_periph_rcv_t exp_rcv(input logic [15:0] s,
      input logic [7:0] p, input logic [1:0] a);
    scg_periph_rcv_t r;
    r.rxd = ~s[10] & p[6];
    r.scl = (s[11] & p[7]) | (s[4] & p[0]);
    r.sda = (s[10] & p[6]) | (s[5] & p[1]);
    r.tmr[0] = ~s[8] & p[4];
    r.tmr[1] = ~s[9] & p[5];
    r.tmr[2] = (s[6] & p[2]) | ((s[1:0] == 2'b11) & a[0]);
    r.tmr[3] = (s[7] & p[3]) | ((s[3:2] == 2'b11) & a[1]);
    r.fault[3] = s[9] & p[5];
    r.fault[2] = (s[3:2] == 2'b10) & a[1];
    r.fault[1] = (s[1:0] == 2'b10) & a[0];
    r.mosi = ~s[7] & p[3];
    r.miso = ~s[6] & p[2];
    r.ss = ~s[5] & p[1];
    r.sclk = ~s[4] & p[0];
    return r;
  endfunction

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Whole run is under two hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    short_off <= 6'h15;
    repeat (2) @(posedge clk);
    #1 chk("short_addr", {2'b11, 16'hFFFF, 6'h15}, short_addr);
    for (int i = 0; i < 5; i++)
    begin
      bus_rd(offs[i], d);
      chk("reset value", rstv[i], d);
      bus_wr(offs[i], 16'hFFFF);
      bus_rd(offs[i], d);
      chk("ones read", msk[i], d);
      @(posedge clk);
      #1 chk("rdata idle", 16'h0000, rdata);
      bus_wr(offs[i], 16'h0000);
      bus_rd(offs[i], d);
      chk("zero read", 16'h0000, d);
    end
    bus_wr(`SCG_OFF_SAHI, 16'hFFFD);
    bus_wr(`SCG_OFF_SALO, 16'h1234);
    short_off <= 6'h2A;
    repeat (6) @(posedge clk);
    #1 chk("short_addr", {2'b01, 16'h1234, 6'h2A}, short_addr);
    for (int i = 0; i < 6; i++)
    begin
      bus_wr(`SCG_OFF_PCE, 16'h0001 << gbit[i]);
      count8();
      chk_cnt("sys tick", 4, sys_n);
      for (int j = 0; j < 6; j++)
        chk_cnt("gate", (i == j) ? 4 : 0, pn[5 - j]);
    end
    @(posedge clk);
    sys_run <= 1'b0;
    count8();
    chk_cnt("halted", 0, sys_n + pn[0]);
    @(posedge clk);
    sys_run <= 1'b1;
    bus_wr(`SCG_OFF_PCE, 16'h0000);
    bus_wr_rd(`SCG_OFF_GPS, 16'h4000, d);
    chk("gps back to back", 16'h4000, d);
    repeat (2) @(posedge clk);
    #1 chk("fast sel", 2'b00, {pwm_fast, fast_en});
    bus_wr(`SCG_OFF_PCE, 16'h0001);
    count8();
    chk_cnt("pwm no pll", 4, pn[0]);
    bus_wr(`SCG_OFF_PCE, 16'h0000);
    pll_sel <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("fast sel", 2'b11, {pwm_fast, fast_en});
    bus_wr(`SCG_OFF_PCE, 16'h0001);
    count8();
    chk_cnt("pwm fast", 8, pn[0]);
    bus_wr(`SCG_OFF_PCE, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      bus_wr(`SCG_OFF_GPS, ps[k]);
      pb_en <= pe[k];
      pb_in <= pi[k];
      pa_en <= ae[k];
      pa_in <= ai[k];
      drv <= dv[k];
      repeat (2) @(posedge clk);
      #1 ep = exp_pins(ps[k], pe[k], ae[k], dv[k]);
      chk("rate", 1'b0, pwm_fast);
      chk("pb_oe", ep[15:8], pb_oe);
      chk("pb_out", ep[7:0], pb_out & ep[15:8]);
      chk("pa_oe", ep[19:18], pa_oe);
      chk("pa_out", ep[17:16], pa_out & ep[19:18]);
      chk("rcv", exp_rcv(ps[k], pi[k] & pe[k], ai[k] & ae[k]), rcv);
    end
    final_report();
  end
endmodule

`default_nettype wire
